// ---- hw/eec_controller.v ----
// Contract
// (R1) op code plus pending flag starts one command
// (R2) reload re-reads config; other codes reserved
// (R3) missing A5h signature fails the reload
// (R4) reload drops ready until it finishes
// (R5) loaded flag only on valid, complete load
// (R6) loaded flag cleared by resets, reload, W1C
// (R7) sticky failure flag, reset zero, W1C
// (R8) write unanswered within 30 ms times out
// (R9) missing acknowledge or bad op code fails
// (R10) clock held low over 30 ms fails
// (R11) bus not won in 1.92 s fails
// (R12) sixteen-bit byte location, resets to zero
// (R13) eight-bit data, upper bits read zero
// (R14) write stores data byte at location
// (R15) I2C master start, address, ack, stop
`timescale 1ns/1ps
`default_nettype none
`include "eec_defs.vh"
module eec_controller #(
  parameter       TW          = `EEC_TMO_W,
  parameter       QTR_CYC     = `EEC_QTR_CYC,
  parameter       WR_TMO_CYC  = `EEC_WR_TMO_CYC,
  parameter       STRETCH_CYC = `EEC_STRETCH_CYC,
  parameter       ARB_CYC     = `EEC_ARB_CYC,
  parameter [6:0] DEV_ADDR    = `EEC_DEV_ADDR
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        clkEn,
  input  wire        softRst,
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         irq,
  output reg         devReady,
  output reg  [7:0]  cfgByte,
  input  wire        i2cSclIn,
  input  wire        i2cSdaIn,
  output wire        i2cSclOut,
  output wire        i2cSdaOut,
  output wire        i2cSclOeN,
  output wire        i2cSdaOeN
);
  localparam [1:0] C_IDLE = 2'h0, C_ISSUE = 2'h1, C_WAIT = 2'h2, C_END = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // registers and bus

  reg         pending_r;
  reg  [2:0]  opCode_r;
  reg         failed_r;
  reg         loaded_r;
  reg  [15:0] byteLoc_r;
  reg  [7:0]  dataByte_r;
  reg  [2:0]  irqStat_r;
  reg  [2:0]  irqMask_r;
  reg  [31:0] rdMux;
  wire [31:0] laneMask;
  wire [31:0] wd;
  wire        wrAcc = avs_write && !avs_waitrequest;
  wire        wrCmd = wrAcc && (avs_address == `EEC_REG_CMD);
  wire        wrDat = wrAcc && (avs_address == `EEC_REG_DATA);
  wire        wrSta = wrAcc && (avs_address == `EEC_REG_IRQ_STAT);
  wire        wrMsk = wrAcc && (avs_address == `EEC_REG_IRQ_MASK);

  // sequencer pulses, one cycle each
  reg         evDone_r;
  reg         evFail_r;
  reg         evLoaded_r;
  reg         evRead_r;
  reg         evReload_r;
  reg  [7:0]  rx_r;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gLane
      assign laneMask[8*g+7:8*g] = {8{avs_byteenable[g]}};
    end
  endgenerate
  assign wd = avs_writedata & laneMask;

  function [15:0] mergeLoc;
    input [15:0] old;
    input [15:0] val;
    input [15:0] msk;
    begin
      mergeLoc = (old & ~msk) | (val & msk);
    end
  endfunction

  always @* begin
    case (avs_address)
      `EEC_REG_CMD:      rdMux = {pending_r, opCode_r, 10'h000, failed_r, loaded_r, byteLoc_r};
      `EEC_REG_DATA:     rdMux = {24'h000000, dataByte_r};             // [R13]
      `EEC_REG_HWCFG:    rdMux = {16'h0000, cfgByte, 7'h00, devReady};
      `EEC_REG_IRQ_STAT: rdMux = {29'h00000000, irqStat_r};
      `EEC_REG_IRQ_MASK: rdMux = {29'h00000000, irqMask_r};
      default:           rdMux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      pending_r       <= 1'b0;
      opCode_r        <= `EEC_RST_OP;
      failed_r        <= 1'b0;                                        // [R7]
      loaded_r        <= 1'b0;                                        // [R6]
      byteLoc_r       <= `EEC_RST_LOC;                                // [R12]
      dataByte_r      <= `EEC_RST_DATA;
      irqStat_r       <= 3'h0;
      irqMask_r       <= 3'h0;
      irq             <= 1'b0;
      devReady        <= 1'b1;
    end else if (clkEn) begin
      // one wait cycle, then a single answer cycle
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (avs_read || avs_write) begin
        avs_waitrequest <= 1'b0;
        if (avs_read) avs_readdata <= rdMux;
      end
      // a command is accepted only while the previous one is not pending
      if (evDone_r) begin
        pending_r <= 1'b0;
      end else if (wrCmd && !pending_r && avs_byteenable[3]) begin
        opCode_r  <= wd[`EEC_CMD_OP_HI:`EEC_CMD_OP_LO];
        pending_r <= wd[`EEC_CMD_PENDING];                            // [R1]
      end
      if (wrCmd)
        byteLoc_r <= mergeLoc(byteLoc_r, wd[15:0], laneMask[15:0]);  // [R12]
      // hardware set wins over a software clear in the same cycle
      failed_r <= evFail_r | (failed_r & ~(wrCmd & wd[`EEC_CMD_FAILED]));   // [R7]
      loaded_r <= evLoaded_r |
                  (loaded_r & ~(wrCmd & wd[`EEC_CMD_LOADED]) & ~softRst & ~evReload_r); // [R6]
      if (evRead_r)
        dataByte_r <= rx_r;                                           // [R13]
      else if (wrDat && avs_byteenable[0])
        dataByte_r <= wd[7:0];
      if (evReload_r)
        devReady <= 1'b0;                                             // [R4]
      else if (evDone_r)
        devReady <= 1'b1;
      irqStat_r[`EEC_IRQ_DONE]   <= evDone_r |
                                    (irqStat_r[`EEC_IRQ_DONE] & ~(wrSta & wd[`EEC_IRQ_DONE]));
      irqStat_r[`EEC_IRQ_FAIL]   <= evFail_r |
                                    (irqStat_r[`EEC_IRQ_FAIL] & ~(wrSta & wd[`EEC_IRQ_FAIL]));
      irqStat_r[`EEC_IRQ_LOADED] <= evLoaded_r |
                                    (irqStat_r[`EEC_IRQ_LOADED] & ~(wrSta & wd[`EEC_IRQ_LOADED]));
      if (wrMsk && avs_byteenable[0])
        irqMask_r <= wd[2:0];
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command sequencer

  reg  [1:0]  cst_r;
  reg  [3:0]  step_r;
  reg  [15:0] curLoc_r;
  reg         stage_r;
  reg         failPend_r;
  reg         pollOn_r;
  reg         pollAck_r;
  reg  [1:0]  seqOp;
  reg  [7:0]  seqByte;
  wire        isWr = (opCode_r == `EEC_OP_WRITE);
  wire        isReload = (opCode_r == `EEC_OP_RELOAD);
  wire        engDone;
  wire        engErr;
  wire [7:0]  engRx;
  wire        engAck;
  wire        pollExp;

  // a read is a dummy write of the location, repeated start, then one NACKed byte;
  // a write is followed by acknowledge polling until the part finishes its cycle
  always @* begin
    seqOp   = `EEC_I2C_STOP;
    seqByte = 8'hFF;
    case (step_r)
      4'h0: seqOp = `EEC_I2C_START;                                    // [R15]
      4'h1: begin
        seqOp   = `EEC_I2C_WRITE;
        seqByte = {DEV_ADDR, 1'b0};
      end
      4'h2: begin
        seqOp   = `EEC_I2C_WRITE;
        seqByte = curLoc_r[15:8];
      end
      4'h3: begin
        seqOp   = `EEC_I2C_WRITE;
        seqByte = curLoc_r[7:0];
      end
      4'h4: begin
        seqOp   = isWr ? `EEC_I2C_WRITE : `EEC_I2C_START;
        seqByte = dataByte_r;                                          // [R14]
      end
      4'h5: begin
        seqOp   = isWr ? `EEC_I2C_STOP : `EEC_I2C_WRITE;
        seqByte = {DEV_ADDR, 1'b1};
      end
      4'h6: seqOp = isWr ? `EEC_I2C_START : `EEC_I2C_READ;
      4'h7: begin
        seqOp   = isWr ? `EEC_I2C_WRITE : `EEC_I2C_STOP;
        seqByte = {DEV_ADDR, 1'b0};
      end
      default: seqOp = `EEC_I2C_STOP;
    endcase
  end

  task finish;
    input bad;
    begin
      evDone_r <= 1'b1;
      evFail_r <= bad;
      pollOn_r <= 1'b0;
      cst_r    <= C_END;
    end
  endtask

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cst_r      <= C_IDLE;
      step_r     <= 4'h0;
      curLoc_r   <= `EEC_RST_LOC;
      stage_r    <= 1'b0;
      failPend_r <= 1'b0;
      pollOn_r   <= 1'b0;
      pollAck_r  <= 1'b0;
      rx_r       <= 8'h00;
      cfgByte    <= 8'h00;
      evDone_r   <= 1'b0;
      evFail_r   <= 1'b0;
      evLoaded_r <= 1'b0;
      evRead_r   <= 1'b0;
      evReload_r <= 1'b0;
    end else if (clkEn) begin
      evDone_r   <= 1'b0;
      evFail_r   <= 1'b0;
      evLoaded_r <= 1'b0;
      evRead_r   <= 1'b0;
      evReload_r <= 1'b0;
      case (cst_r)
        C_IDLE: begin
          step_r     <= 4'h0;
          stage_r    <= 1'b0;
          failPend_r <= 1'b0;
          pollAck_r  <= 1'b0;
          curLoc_r   <= byteLoc_r;
          if (pending_r) begin                                          // [R1]
            if (isReload) begin
              curLoc_r   <= `EEC_SIG_LOC;
              evReload_r <= 1'b1;                                       // [R2] [R4] [R6]
              cst_r      <= C_ISSUE;
            end else if (isWr || opCode_r == `EEC_OP_READ) begin
              cst_r <= C_ISSUE;
            end else begin
              finish(1'b1);                                             // [R9]
            end
          end
        end
        C_ISSUE: cst_r <= C_WAIT;
        C_WAIT: begin
          if (engDone) begin
            cst_r <= C_ISSUE;
            if (engErr) begin
              finish(1'b1);                                             // [R10] [R11]
            end else if (isWr && step_r == 4'h7) begin
              pollAck_r <= engAck;
              step_r    <= 4'h8;
            end else if (seqOp == `EEC_I2C_WRITE && !engAck) begin
              failPend_r <= 1'b1;                                       // [R9]
              step_r     <= isWr ? 4'h5 : 4'h7;
            end else if (isWr && step_r == 4'h5) begin
              if (failPend_r) begin
                finish(1'b1);
              end else begin
                pollOn_r <= 1'b1;
                step_r   <= 4'h6;
              end
            end else if (isWr && step_r == 4'h8) begin
              if (pollAck_r)
                finish(1'b0);                                           // [R14]
              else if (pollExp)
                finish(1'b1);                                           // [R8]
              else
                step_r <= 4'h6;
            end else if (!isWr && step_r == 4'h7) begin
              if (failPend_r) begin
                finish(1'b1);
              end else if (!isReload) begin
                evRead_r <= 1'b1;
                finish(1'b0);
              end else if (!stage_r) begin
                if (rx_r == `EEC_SIGNATURE) begin
                  stage_r  <= 1'b1;
                  curLoc_r <= `EEC_CFG_LOC;
                  step_r   <= 4'h0;
                end else begin
                  finish(1'b1);                                         // [R3]
                end
              end else begin
                cfgByte    <= rx_r;
                evLoaded_r <= 1'b1;                                     // [R5]
                finish(1'b0);
              end
            end else begin
              if (step_r == 4'h6) rx_r <= engRx;
              step_r <= step_r + 1'b1;
            end
          end
        end
        default: cst_r <= C_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial side

  eec_timeout_cnt #(.W(TW), .LIMIT(WR_TMO_CYC)) uPoll (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .run      (pollOn_r),
    .expired  (pollExp)
  );

  eec_i2c_engine #(
    .QTR         (QTR_CYC),
    .TW          (TW),
    .STRETCH_CYC (STRETCH_CYC),
    .ARB_CYC     (ARB_CYC)
  ) uEngine (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .cmdValid (cst_r == C_ISSUE),
    .cmdOp    (seqOp),
    .cmdByte  (seqByte),
    .cmdNack  (1'b1),
    .cmdDone  (engDone),
    .cmdErr   (engErr),
    .rxByte   (engRx),
    .ackSeen  (engAck),
    .sclIn    (i2cSclIn),
    .sdaIn    (i2cSdaIn),
    .sclOut   (i2cSclOut),
    .sdaOut   (i2cSdaOut),
    .sclOeN   (i2cSclOeN),
    .sdaOeN   (i2cSdaOeN)
  );
endmodule
`default_nettype wire

// ---- hw/eec_defs.vh ----
`ifndef EEC_DEFS_VH
`define EEC_DEFS_VH

// register byte addresses
`define EEC_REG_CMD        9'h1B4
`define EEC_REG_DATA       9'h1B8
`define EEC_REG_HWCFG      9'h1BC
`define EEC_REG_IRQ_STAT   9'h1C0
`define EEC_REG_IRQ_MASK   9'h1C4

// command/status field positions
`define EEC_CMD_PENDING    31
`define EEC_CMD_OP_HI      30
`define EEC_CMD_OP_LO      28
`define EEC_CMD_FAILED     17
`define EEC_CMD_LOADED     16

// interrupt status/mask bits
`define EEC_IRQ_DONE       0
`define EEC_IRQ_FAIL       1
`define EEC_IRQ_LOADED     2

// operation codes
`define EEC_OP_READ        3'h0
`define EEC_OP_WRITE       3'h3
`define EEC_OP_RELOAD      3'h7

// reset values
`define EEC_RST_LOC        16'h0000
`define EEC_RST_DATA       8'h00
`define EEC_RST_OP         3'h0

// reload layout
`define EEC_SIGNATURE      8'hA5
`define EEC_SIG_LOC        16'h0000
`define EEC_CFG_LOC        16'h0001
`define EEC_DEV_ADDR       7'h50

// byte engine commands
`define EEC_I2C_START      2'h0
`define EEC_I2C_WRITE      2'h1
`define EEC_I2C_READ       2'h2
`define EEC_I2C_STOP       2'h3

// timing
`define EEC_CLK_KHZ        40000
`define EEC_SCL_KHZ        100
`define EEC_QTR_CYC        (`EEC_CLK_KHZ / (4 * `EEC_SCL_KHZ))
`define EEC_WR_TMO_MS      30
`define EEC_WR_TMO_CYC     (`EEC_WR_TMO_MS * `EEC_CLK_KHZ)
`define EEC_STRETCH_MS     30
`define EEC_STRETCH_CYC    (`EEC_STRETCH_MS * `EEC_CLK_KHZ)
`define EEC_ARB_CS         192
`define EEC_ARB_CYC        (`EEC_ARB_CS * 10 * `EEC_CLK_KHZ)
`define EEC_TMO_W          27

`endif

// ---- hw/eec_timeout_cnt.v ----
`timescale 1ns/1ps
`default_nettype none
module eec_timeout_cnt #(
  parameter W     = 27,
  parameter LIMIT = 1200000
) (
  input  wire core_clk,
  input  wire sys_rst,
  input  wire clkEn,
  input  wire run,
  output reg  expired
);
  localparam integer LAST = LIMIT - 1;
  reg [W-1:0] cnt_r;

  // expired rises LIMIT cycles after run rises and clears with run
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r   <= {W{1'b0}};
      expired <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        cnt_r   <= {W{1'b0}};
        expired <= 1'b0;
      end else if (cnt_r == LAST[W-1:0]) begin
        expired <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/eec_i2c_engine.v ----
`timescale 1ns/1ps
`default_nettype none
`include "eec_defs.vh"
module eec_i2c_engine #(
  parameter QTR         = 100,
  parameter TW          = 27,
  parameter STRETCH_CYC = 1200000,
  parameter ARB_CYC     = 76800000
) (
  input  wire       core_clk,
  input  wire       sys_rst,
  input  wire       clkEn,
  input  wire       cmdValid,
  input  wire [1:0] cmdOp,
  input  wire [7:0] cmdByte,
  input  wire       cmdNack,
  output reg        cmdDone,
  output reg        cmdErr,
  output wire [7:0] rxByte,
  output wire       ackSeen,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sclOut,
  output reg        sdaOut,
  output reg        sclOeN,
  output reg        sdaOeN
);
  localparam [2:0] S_IDLE = 3'h0, S_FREE = 3'h1, S_START = 3'h2, S_BIT = 3'h3, S_STOP = 3'h4;
  localparam integer QLAST = QTR - 1;

  reg  [2:0]  st_r;
  reg  [1:0]  ph_r;
  reg  [15:0] q_r;
  reg  [3:0]  bit_r;
  reg  [8:0]  sh_r;
  wire        tick     = (q_r == QLAST[15:0]);
  wire        onLine   = (st_r == S_START) || (st_r == S_BIT) || (st_r == S_STOP);
  // slave holding scl low after we released it freezes the bit timing
  wire        stallScl = onLine && (ph_r == 2'h1) && !sclIn;
  wire        strExp;
  wire        arbExp;

  assign rxByte  = sh_r[8:1];
  assign ackSeen = !sh_r[0];

  eec_timeout_cnt #(.W(TW), .LIMIT(STRETCH_CYC)) uStretch (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .run      (stallScl),
    .expired  (strExp)
  );

  eec_timeout_cnt #(.W(TW), .LIMIT(ARB_CYC)) uArb (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .run      (st_r == S_FREE),
    .expired  (arbExp)
  );

  always @(posedge core_clk) begin
    if (sys_rst) begin
      st_r    <= S_IDLE;
      ph_r    <= 2'h0;
      q_r     <= 16'h0000;
      bit_r   <= 4'h0;
      sh_r    <= 9'h1FF;
      cmdDone <= 1'b0;
      cmdErr  <= 1'b0;
      sclOut  <= 1'b0;
      sdaOut  <= 1'b0;
      sclOeN  <= 1'b1;
      sdaOeN  <= 1'b1;
    end else if (clkEn) begin
      cmdDone <= 1'b0;
      cmdErr  <= 1'b0;
      case (st_r)
        S_IDLE: begin
          q_r   <= 16'h0000;
          ph_r  <= 2'h0;
          bit_r <= 4'h0;
          if (cmdValid) begin
            case (cmdOp)
              `EEC_I2C_START: begin
                sdaOeN <= 1'b1;
                st_r   <= sclOeN ? S_FREE : S_START;   // repeated start skips the bus wait
              end
              `EEC_I2C_WRITE: begin
                sh_r   <= {cmdByte, 1'b1};
                sdaOeN <= cmdByte[7];
                st_r   <= S_BIT;
              end
              `EEC_I2C_READ: begin
                sh_r   <= {8'hFF, cmdNack};
                sdaOeN <= 1'b1;
                st_r   <= S_BIT;
              end
              default: begin
                sdaOeN <= 1'b0;
                st_r   <= S_STOP;
              end
            endcase
          end
        end
        S_FREE: begin
          if (arbExp) begin                             // [R11]
            st_r    <= S_IDLE;
            cmdDone <= 1'b1;
            cmdErr  <= 1'b1;
          end else if (sclIn && sdaIn) begin
            q_r <= tick ? 16'h0000 : q_r + 1'b1;
            if (tick) st_r <= S_START;
          end else begin
            q_r <= 16'h0000;
          end
        end
        default: begin
          if (strExp) begin                             // [R10]
            st_r    <= S_IDLE;
            cmdDone <= 1'b1;
            cmdErr  <= 1'b1;
            sclOeN  <= 1'b1;
            sdaOeN  <= 1'b1;
          end else if (!stallScl) begin
            if (!tick) begin
              q_r <= q_r + 1'b1;
            end else begin
              q_r  <= 16'h0000;
              ph_r <= ph_r + 1'b1;
              case (ph_r)
                2'h0: sclOeN <= 1'b1;
                2'h1: begin
                  if (st_r == S_START) sdaOeN <= 1'b0;   // [R15]
                  if (st_r == S_BIT) sh_r <= {sh_r[7:0], sdaIn};
                  if (st_r == S_STOP) sdaOeN <= 1'b1;
                end
                2'h2: if (st_r != S_STOP) sclOeN <= 1'b0;
                default: begin
                  if (st_r != S_BIT || bit_r == 4'h8) begin
                    st_r    <= S_IDLE;
                    cmdDone <= 1'b1;
                  end else begin
                    bit_r  <= bit_r + 1'b1;
                    sdaOeN <= sh_r[8];
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/eec_controller_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eec_defs.vh"
module eec_controller_assertions (
  input wire        core_clk,
  input wire        sys_rst,
  input wire        clkEn,
  input wire [8:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        devReady,
  input wire [7:0]  cfgByte,
  input wire        i2cSclOut,
  input wire        i2cSdaOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  property p_ans;
    (avs_read || avs_write) && avs_waitrequest && clkEn |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("request not answered");
  property p_one;
    clkEn && !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_upper;
    !avs_waitrequest && $past(avs_read) && $past(avs_address) == `EEC_REG_DATA
      |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("data upper bits set");
  property p_hold;
    !($past(avs_read) && $past(avs_waitrequest)) |-> $stable(avs_readdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // a reload taken while idle drops ready
  property p_drop;
    avs_write && !avs_waitrequest && avs_address == `EEC_REG_CMD && devReady
      && avs_writedata[31:28] == 4'hF && avs_byteenable[3] |-> ##[1:3] !devReady;
  endproperty
  a_drop: assert property (p_drop) else $error("ready kept after reload");
  property p_low;
    $fell(devReady) |-> !devReady [*8];
  endproperty
  a_low: assert property (p_low) else $error("ready back too soon");
  property p_cfg;
    !$stable(cfgByte) |-> !$past(devReady);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config outside reload");
  property p_od;
    !i2cSclOut && !i2cSdaOut;
  endproperty
  a_od: assert property (p_od) else $error("line driven high");
endmodule
`default_nettype wire

// ---- tb/eec_eeprom_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eec_eeprom_model (
  input  wire scl,
  input  wire sda,
  input  wire nackAll,
  input  wire stretch,
  input  wire busBusy,
  output wire sdaLow,
  output reg  sclLow
);
  reg [7:0]  mem [0:65535];
  reg [7:0]  sh;
  reg [7:0]  dat;
  reg [15:0] loc;
  reg [1:0]  idx;
  reg        on;
  reg        rdm;
  reg        rdNext;
  reg        mack;
  reg        drv;
  integer    cnt;
  assign sdaLow = drv | busBusy;
  initial begin
    on = 1'b0;
    drv = 1'b0;
    sclLow = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // start keeps the location for random reads
  always @(negedge sda) if (scl === 1'b1) begin
    on = 1'b1;
    cnt = -1;
    idx = 2'd0;
    rdm = 1'b0;
    rdNext = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    on = 1'b0;
    drv = 1'b0;
  end
  always @(negedge stretch) sclLow = 1'b0;
  always @(posedge scl) if (on) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else mack = !sda;
  end
  always @(negedge scl) if (on) begin
    if (stretch) sclLow = 1'b1;
    cnt = cnt + 1;
    if (cnt == 8) begin
      drv = !rdm && !nackAll && (idx != 2'd0 || sh[7:1] == 7'h50);
      if (idx == 2'd0) rdNext = sh[0];
      if (idx == 2'd1) loc[15:8] = sh;
      if (idx == 2'd2) loc[7:0] = sh;
      if (idx == 2'd3 && !rdNext) mem[loc] = sh;
      if (idx == 2'd3) loc = loc + 16'h1;
      idx = (idx == 2'd3 || rdNext) ? 2'd3 : idx + 2'd1;
    end else if (cnt == 9) begin
      cnt = 0;
      rdm = rdNext && (rdm ? mack : drv);
      dat = mem[loc];
      drv = rdm && !dat[7];
    end else if (rdm) drv = !dat[7 - cnt];
  end
endmodule
`default_nettype wire

// ---- tb/eec_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eec_defs.vh"
module eec_controller_tb;
  localparam [8:0] ACMD = `EEC_REG_CMD;
  localparam [8:0] AHW  = `EEC_REG_HWCFG;
  localparam [8:0] ADAT = `EEC_REG_DATA;
  logic        core_clk, sys_rst, softRst, nackAll, stretch, busBusy;
  logic [8:0]  avs_address;
  logic        avs_read, avs_write;
  logic [31:0] avs_writedata, rdq;
  logic [3:0]  avs_byteenable = 4'hF;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, irq, devReady, sclOeN, sdaOeN, sdaLow, sclLow;
  wire  [7:0]  cfgByte;
  wire         sclLine = sclOeN & !sclLow;
  wire         sdaLine = sdaOeN & !sdaLow;
  integer      nMismatch, testsRun, i;
  always #12.5 core_clk = ~core_clk;
  eec_controller #(.QTR_CYC(4), .WR_TMO_CYC(200), .STRETCH_CYC(100), .ARB_CYC(300))
  u_eec_controller (.core_clk, .sys_rst, .clkEn(1'b1), .softRst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .irq, .devReady, .cfgByte, .i2cSclIn(sclLine),
    .i2cSdaIn(sdaLine), .i2cSclOut(), .i2cSdaOut(), .i2cSclOeN(sclOeN),
    .i2cSdaOeN(sdaOeN));
  eec_eeprom_model u_eec_eeprom_model (.scl(sclLine), .sda(sdaLine), .nackAll,
    .stretch, .busBusy, .sdaLow, .sclLow);
  ////////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      if (nMismatch == 0 && testsRun > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      testsRun = testsRun + 1;
      if (got !== exp) begin
        nMismatch = nMismatch + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // hold request until waitrequest is seen low
  task acc(input logic rd, input logic [8:0] a, input logic [31:0] d);
    begin
      @(posedge core_clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      rdq = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rchk(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
      acc(1'b1, a, 32'h0);
      chk(rdq & m, e);
    end
  endtask
  task poll(input logic [8:0] a, input integer b, input logic v);
    begin
      acc(1'b1, a, 32'h0);
      while (rdq[b] !== v) acc(1'b1, a, 32'h0);
    end
  endtask
  task cmd(input logic [2:0] op, input logic [15:0] loc);
    begin
      acc(1'b0, ACMD, {1'b1, op, 12'h000, loc});
      poll(ACMD, 31, 1'b0);
    end
  endtask
  task reload(input logic [7:0] sig);
    begin
      u_eec_eeprom_model.mem[0] = sig;
      acc(1'b0, ACMD, 32'hF0000000);
      repeat (3) @(posedge core_clk);
      chk({31'h0, devReady}, 32'h0);
      poll(AHW, 0, 1'b1);
      poll(ACMD, 31, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    softRst = 1'b0;
    nackAll = 1'b0;
    stretch = 1'b0;
    busBusy = 1'b0;
    avs_address = 9'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    nMismatch = 0;
    testsRun = 0;
    u_eec_eeprom_model.mem[16'hBEEF] = 8'hC3;
    u_eec_eeprom_model.mem[1] = 8'h3C;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(ACMD, 32'hFFFFFFFF, 32'h0);
    rchk(ADAT, 32'hFFFFFFFF, 32'h0);
    rchk(AHW, 32'h1, 32'h1);
    acc(1'b0, ADAT, 32'hFFFFFF5A);
    rchk(ADAT, 32'hFFFFFFFF, 32'h5A);
    avs_byteenable <= 4'hE;
    acc(1'b0, ADAT, 32'h0);
    avs_byteenable <= 4'hF;
    acc(1'b0, 9'h1F8, 32'hFFFFFFFF);
    rchk(9'h1F8, 32'hFFFFFFFF, 32'h0);
    cmd(`EEC_OP_WRITE, 16'h1234);
    chk({24'h0, u_eec_eeprom_model.mem[16'h1234]}, 32'h5A);
    rchk(ACMD, 32'h8003FFFF, 32'h1234);
    cmd(`EEC_OP_READ, 16'hBEEF);
    rchk(ADAT, 32'hFFFFFFFF, 32'hC3);
    for (i = 1; i < 7; i = i + 1) if (i != 3) begin
      cmd(i[2:0], 16'h0);
      rchk(ACMD, 32'h00020000, 32'h00020000);
      acc(1'b0, ACMD, 32'h00020000);
      rchk(ACMD, 32'h00020000, 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
    acc(1'b0, `EEC_REG_IRQ_MASK, 32'h2);
    rchk(`EEC_REG_IRQ_STAT, 32'h7, 32'h3);
    chk({31'h0, irq}, 32'h1);
    acc(1'b0, `EEC_REG_IRQ_STAT, 32'h7);
    rchk(`EEC_REG_IRQ_STAT, 32'h7, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // nack, held clock, busy bus
    for (i = 0; i < 3; i = i + 1) begin
      nackAll <= (i == 0);
      stretch <= (i == 1);
      busBusy <= (i == 2);
      cmd(`EEC_OP_READ, 16'h0005);
      rchk(ACMD, 32'h00020000, 32'h00020000);
      acc(1'b0, ACMD, 32'h00020000);
    end
    busBusy <= 1'b0;
    reload(8'h00);
    rchk(ACMD, 32'h00030000, 32'h00020000);
    chk({24'h0, cfgByte}, 32'h0);
    reload(`EEC_SIGNATURE);
    rchk(AHW, 32'hFF01, 32'h3C01);
    rchk(ACMD, 32'h00010000, 32'h00010000);
    softRst <= 1'b1;
    @(posedge core_clk);
    softRst <= 1'b0;
    rchk(ACMD, 32'h00010000, 32'h0);
    reload(`EEC_SIGNATURE);
    reload(8'h00);
    rchk(ACMD, 32'h00010000, 32'h0);
    reload(`EEC_SIGNATURE);
    acc(1'b0, ACMD, 32'h00010000);
    rchk(ACMD, 32'h00010000, 32'h0);
    give_verdict;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    nMismatch = nMismatch + 1;
    $display("mismatch at %0t: timeout", $time);
    give_verdict;
  end
endmodule
bind eec_controller eec_controller_assertions u_eec_controller_assertions (.*);
`default_nettype wire
